// ==== rtl/lsw_port.sv ====
// Downstream port link suspend, wake and latency tolerance sequencer
`timescale 1ns/1ns
// Contract
// - On a U3 request the port sends the go-to-U3 link command.
// - After the partner's acceptance the port sends the power-management ack.
// - After the ack exchange both ends idle transmitters and enter U3.
// - A suspended function waking remotely sends LFPS to its partner.
// - A hub in U3 passes wake LFPS upstream; a non-U3 hub controls.
// - The controlling hub reflects LFPS out of the port that received it.
// - Hubs forward wake down the receiving port; each link reaches U0.
// - When links are in U0 the waking function sends a wake notification.
// - Report one tolerance, following the smallest configured endpoint.
// - The reported tolerance may change at run time, e.g. idle periods.
// - With U2 allowed, tolerance is intrinsic minus U2 exit latency.
// - With only U1 allowed, tolerance is intrinsic minus U1 exit latency.
// - A hub holds ERDY up to one max packet, else about 250 ns.
// - Link-change flag sets on host wake completion, never on remote wake.
module lsw_port
    import lsw_pkg::*;
(
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic link_u3_req, // Request U0 to U3, pulse
    input wire logic link_wake_req, // Request host wake U3 to U0, pulse
    input wire logic func_wake_req, // Local function remote wake, pulse
    input wire logic up_port_in_u3, // Upstream port of this hub is in U3
    input wire lsw_lcmd_t lcmd_rx, // Link command from partner
    input wire logic lfps_rx_pin, // Wake LFPS detected from partner, async
    input wire logic up_lfps_rx_pin, // Wake LFPS reflected from upstream, async
    input wire logic link_chg_clr, // Clear link-change flag, pulse
    input wire logic erdy_in, // ERDY arriving from below, pulse
    input wire logic xfer_busy, // Upstream transfer in progress
    input wire lsw_belt_cfg_t belt_cfg, // Exit latencies and link enables
    input wire logic [NEP-1:0][TOL_W-1:0] ep_tol, // Endpoint tolerances, ns
    input wire logic [NEP-1:0] ep_cfg, // Endpoint configured mask
    output lsw_lcmd_t lcmd_tx, // Link command to partner
    output logic tx_eidle, // Transmitter in electrical idle
    output logic link_in_u3, // Link is in U3
    output logic lfps_tx, // Drive wake LFPS toward partner
    output logic up_lfps_tx, // Drive wake LFPS upstream
    output logic link_chg, // Host wake completed flag
    output logic wake_notify, // Send function wake notification, pulse
    output logic erdy_out, // Forwarded ERDY, pulse
    output logic [TOL_W-1:0] belt_val, // Reported tolerance
    output logic belt_upd // Reported tolerance changed, pulse
);

    typedef struct packed {
        lsw_state_t st;
        lsw_wake_t kind;
        logic [CNT_W-1:0] cnt;
        lsw_lcmd_t lcmd;
        logic eidle;
        logic in_u3;
        logic lfps;
        logic up_lfps;
        logic chg;
        logic notify;
        logic [1:0] lfps_sync;
        logic [1:0] up_sync;
        logic lfps_prev;
        logic erdy_pend;
        logic [CNT_W-1:0] ecnt;
        logic erdy;
        logic [TOL_W-1:0] belt;
        logic belt_upd;
    } lsw_port_st_t;

    lsw_port_st_t r_reg;
    lsw_port_st_t r_next;
    logic [TOL_W-1:0] belt_calc;
    logic [TOL_W-1:0] base_tol;
    logic lfps_s;
    logic up_lfps_s;
    logic lfps_rise;
    logic acc_rx;

    lsw_belt u_belt (
        .ep_tol(ep_tol),
        .ep_cfg(ep_cfg),
        .cfg(belt_cfg),
        .base_tol(base_tol),
        .belt(belt_calc)
    );

    assign lfps_s = r_reg.lfps_sync[1];
    assign up_lfps_s = r_reg.up_sync[1];
    assign lfps_rise = lfps_s && !r_reg.lfps_prev;
    // The partner never refuses, so acceptance is the only answer awaited
    assign acc_rx = lcmd_rx.valid && (lcmd_rx.code == LC_ACCEPT);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_next = r_reg;
        r_next.lfps_sync = {r_reg.lfps_sync[0], lfps_rx_pin};
        r_next.up_sync = {r_reg.up_sync[0], up_lfps_rx_pin};
        r_next.lfps_prev = lfps_s;
        r_next.lcmd = '{valid: 1'b0, code: LC_NONE};
        r_next.notify = 1'b0;
        r_next.erdy = 1'b0;
        r_next.chg = r_reg.chg && !link_chg_clr;

        unique case (r_reg.st)
            ST_U0:
            begin
                if (link_u3_req)
                begin
                    r_next.lcmd = '{valid: 1'b1, code: LC_GO_U3};
                    r_next.st = ST_WAIT_ACC;
                end
            end
            ST_WAIT_ACC:
            begin
                if (acc_rx)
                begin
                    r_next.lcmd = '{valid: 1'b1, code: LC_PM_ACK};
                    r_next.st = ST_ENTER_U3;
                end
            end
            ST_ENTER_U3:
            begin
                r_next.eidle = 1'b1;
                r_next.in_u3 = 1'b1;
                r_next.st = ST_U3;
            end
            ST_U3:
            begin
                // Host wake has priority; a crossing remote wake joins its handshake
                if (link_wake_req)
                begin
                    r_next.lfps = 1'b1;
                    r_next.kind = WK_HOST;
                    r_next.st = ST_LFPS_WAIT;
                end
                else if (lfps_rise)
                begin
                    r_next.kind = WK_REMOTE;
                    if (up_port_in_u3)
                    begin
                        r_next.up_lfps = 1'b1;
                        r_next.st = ST_UP_WAIT;
                    end
                    else
                    begin
                        r_next.lfps = 1'b1;
                        r_next.cnt = LFPS_HS_LD;
                        r_next.st = ST_HSHAKE;
                    end
                end
                else if (func_wake_req)
                begin
                    r_next.lfps = 1'b1;
                    r_next.kind = WK_LOCAL;
                    r_next.st = ST_LFPS_WAIT;
                end
            end
            ST_UP_WAIT:
            begin
                if (up_lfps_s)
                begin
                    r_next.up_lfps = 1'b0;
                    r_next.lfps = 1'b1;
                    r_next.cnt = LFPS_HS_LD;
                    r_next.st = ST_HSHAKE;
                end
            end
            ST_LFPS_WAIT:
            begin
                if (lfps_s)
                begin
                    r_next.cnt = LFPS_HS_LD;
                    r_next.st = ST_HSHAKE;
                end
            end
            ST_HSHAKE:
            begin
                if (r_reg.cnt == CNT_ZERO)
                begin
                    r_next.lfps = 1'b0;
                    r_next.eidle = 1'b0;
                    r_next.in_u3 = 1'b0;
                    r_next.st = ST_U0;
                    if (r_reg.kind == WK_HOST)
                    begin
                        r_next.chg = 1'b1;
                    end
                    if (r_reg.kind == WK_LOCAL)
                    begin
                        r_next.notify = 1'b1;
                    end
                end
                else
                begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end
            end
            default:
            begin
                r_next.st = ST_U0;
            end
        endcase

        // A second ERDY while one is held is dropped
        if (r_reg.erdy_pend)
        begin
            if (r_reg.ecnt == CNT_ZERO)
            begin
                r_next.erdy = 1'b1;
                r_next.erdy_pend = 1'b0;
            end
            else if (!xfer_busy && (r_reg.ecnt > HUB_FWD_LD))
            begin
                r_next.ecnt = HUB_FWD_LD;
            end
            else
            begin
                r_next.ecnt = r_reg.ecnt - 8'h01;
            end
        end
        else if (erdy_in)
        begin
            r_next.erdy_pend = 1'b1;
            r_next.ecnt = xfer_busy ? ERDY_HOLD_LD : HUB_FWD_LD;
        end

        r_next.belt = belt_calc;
        r_next.belt_upd = (belt_calc != r_reg.belt);
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign lcmd_tx = r_reg.lcmd;
    assign tx_eidle = r_reg.eidle;
    assign link_in_u3 = r_reg.in_u3;
    assign lfps_tx = r_reg.lfps;
    assign up_lfps_tx = r_reg.up_lfps;
    assign link_chg = r_reg.chg;
    assign wake_notify = r_reg.notify;
    assign erdy_out = r_reg.erdy;
    assign belt_val = r_reg.belt;
    assign belt_upd = r_reg.belt_upd;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_go_u3;
        (r_reg.st == ST_U0) && link_u3_req |=> lcmd_tx.valid && (lcmd_tx.code == LC_GO_U3);
    endproperty
    a_go_u3: assert property (p_go_u3) else $error("no go-U3 after request");

    property p_ack_after_acc;
        (r_reg.st == ST_WAIT_ACC) && acc_rx |=> lcmd_tx.valid && (lcmd_tx.code == LC_PM_ACK)
            ##1 (tx_eidle && link_in_u3);
    endproperty
    a_ack_after_acc: assert property (p_ack_after_acc) else $error("no ack then U3");

    property p_u3_idle;
        $rose(link_in_u3) |-> tx_eidle && $past(lcmd_tx.code) == LC_PM_ACK;
    endproperty
    a_u3_idle: assert property (p_u3_idle) else $error("U3 entered without ack");

    property p_local_lfps;
        (r_reg.st == ST_U3) && func_wake_req && !link_wake_req && !lfps_rise
            |=> lfps_tx && !up_lfps_tx;
    endproperty
    a_local_lfps: assert property (p_local_lfps) else $error("local wake sent no LFPS");

    property p_up_prop;
        (r_reg.st == ST_U3) && !link_wake_req && lfps_rise && up_port_in_u3
            |=> up_lfps_tx && !lfps_tx;
    endproperty
    a_up_prop: assert property (p_up_prop) else $error("wake not passed upstream");

    property p_reflect;
        (r_reg.st == ST_U3) && !link_wake_req && lfps_rise && !up_port_in_u3
            |=> lfps_tx && !up_lfps_tx;
    endproperty
    a_reflect: assert property (p_reflect) else $error("no LFPS reflection");

    property p_hs_len;
        $rose(r_reg.st == ST_HSHAKE) |-> lfps_tx[*8] ##12 (lfps_tx && link_in_u3) ##1 !link_in_u3;
    endproperty
    a_hs_len: assert property (p_hs_len) else $error("handshake length wrong");

    property p_chg_host;
        $rose(link_chg) |-> $past(r_reg.kind) == WK_HOST && !link_in_u3;
    endproperty
    a_chg_host: assert property (p_chg_host) else $error("change flag on non-host wake");

    property p_notify;
        wake_notify |-> !link_in_u3 && (r_reg.kind == WK_LOCAL) && $fell(link_in_u3);
    endproperty
    a_notify: assert property (p_notify) else $error("notify without local wake");

    property p_erdy_bound;
        erdy_in && !r_reg.erdy_pend |-> ##[5:43] erdy_out;
    endproperty
    a_erdy_bound: assert property (p_erdy_bound) else $error("ERDY held too long");

    property p_belt_u2;
        belt_cfg.u2_en && (base_tol > belt_cfg.u2_sel) |=>
            belt_val == $past(belt_calc) &&
            $past(belt_calc) == $past(base_tol) - $past(belt_cfg.u2_sel);
    endproperty
    a_belt_u2: assert property (p_belt_u2) else $error("U2 latency not subtracted");

    property p_belt_upd;
        belt_upd |-> $changed(belt_val);
    endproperty
    a_belt_upd: assert property (p_belt_upd) else $error("update pulse without change");

endmodule

// ==== shared/lsw_pkg.sv ====
// Shared constants and types for the link suspend and wake sequencer
package lsw_pkg;

    localparam int CLK_PERIOD_NS = 50;
    // LFPS handshake hold time before the link counts as U0 (least time, rounds up)
    localparam int LFPS_HS_NS = 1000;
    localparam int LFPS_HS_CYC = (LFPS_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest ERDY hold behind one maximum-size packet (rounds down)
    localparam int ERDY_HOLD_NS = 2100;
    localparam int ERDY_HOLD_CYC = ERDY_HOLD_NS / CLK_PERIOD_NS;
    // Longest per-hub forwarding delay (rounds down)
    localparam int HUB_FWD_NS = 250;
    localparam int HUB_FWD_CYC = HUB_FWD_NS / CLK_PERIOD_NS;

    localparam int CNT_W = 8;
    localparam int NEP = 4;
    localparam int TOL_W = 16;

    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] LFPS_HS_LD = CNT_W'(LFPS_HS_CYC - 1);
    localparam logic [CNT_W-1:0] ERDY_HOLD_LD = CNT_W'(ERDY_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] HUB_FWD_LD = CNT_W'(HUB_FWD_CYC - 1);
    localparam logic [TOL_W-1:0] TOL_ZERO = 16'h0000;
    localparam logic [TOL_W-1:0] TOL_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        LC_NONE = 2'h0,
        LC_GO_U3 = 2'h1,
        LC_ACCEPT = 2'h2,
        LC_PM_ACK = 2'h3
    } lsw_lcmd_code_t;

    typedef struct packed {
        logic valid;
        lsw_lcmd_code_t code;
    } lsw_lcmd_t;

    typedef enum logic [2:0] {
        ST_U0 = 3'h0,
        ST_WAIT_ACC = 3'h1,
        ST_ENTER_U3 = 3'h2,
        ST_U3 = 3'h3,
        ST_UP_WAIT = 3'h4,
        ST_LFPS_WAIT = 3'h5,
        ST_HSHAKE = 3'h6
    } lsw_state_t;

    typedef enum logic [1:0] {
        WK_HOST = 2'h0,
        WK_REMOTE = 2'h1,
        WK_LOCAL = 2'h2
    } lsw_wake_t;

    typedef struct packed {
        logic u1_en;
        logic u2_en;
        logic [TOL_W-1:0] u1_sel;
        logic [TOL_W-1:0] u2_sel;
        logic [TOL_W-1:0] idle_bonus;
    } lsw_belt_cfg_t;

endpackage

// ==== rtl/lsw_belt.sv ====
// Best-effort latency tolerance calculation from endpoint tolerances
`timescale 1ns/1ns
module lsw_belt
    import lsw_pkg::*;
(
    input wire logic [NEP-1:0][TOL_W-1:0] ep_tol, // Per-endpoint tolerance, ns
    input wire logic [NEP-1:0] ep_cfg, // Endpoint configured
    input wire lsw_belt_cfg_t cfg, // Exit latencies and enables
    output logic [TOL_W-1:0] base_tol, // Intrinsic tolerance incl. idle bonus
    output logic [TOL_W-1:0] belt // Reported tolerance
);

    logic [NEP:0][TOL_W-1:0] min_chain;
    logic [TOL_W:0] sum;
    logic [TOL_W-1:0] sel;

    assign min_chain[0] = TOL_MAX;

    // Unconfigured endpoints drop out of the minimum
    genvar i;
    generate
        for (i = 0; i < NEP; i++)
        begin : g_min
            assign min_chain[i+1] = (ep_cfg[i] && (ep_tol[i] < min_chain[i])) ?
                ep_tol[i] : min_chain[i];
        end
    endgenerate

    always_comb
    begin
        sum = {1'b0, min_chain[NEP]} + {1'b0, cfg.idle_bonus};
        base_tol = sum[TOL_W] ? TOL_MAX : sum[TOL_W-1:0];
        if (cfg.u2_en)
        begin
            sel = cfg.u2_sel;
        end
        else if (cfg.u1_en)
        begin
            sel = cfg.u1_sel;
        end
        else
        begin
            sel = TOL_ZERO;
        end
        // Saturate at zero: a negative tolerance means service must be immediate
        belt = (base_tol > sel) ? (base_tol - sel) : TOL_ZERO;
    end

endmodule

// ==== testbench/lsw_partner.sv ====
// Link partner model: accepts U3 entry and answers wake LFPS
`timescale 1ns/1ns
module lsw_partner
    import lsw_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Reset, active low
    input wire lsw_lcmd_t lcmd_tx, // Command from port
    input wire logic lfps_tx, // Wake LFPS from port
    input wire logic [7:0] acc_dly, // Accept delay, cycles
    input wire logic wake_go, // Start remote wake, pulse
    output lsw_lcmd_t lcmd_rx, // Command to port
    output logic lfps_rx_pin // Wake LFPS toward port
);
    int acc_cnt;
    logic wake_pend;
    logic lfps_d;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_cnt <= -1;
            wake_pend <= 1'b0;
            lfps_d <= 1'b0;
            lcmd_rx <= '0;
            lfps_rx_pin <= 1'b0;
        end
        else
        begin
            lcmd_rx <= '0;
            lfps_d <= lfps_tx;
            if (lcmd_tx.valid && lcmd_tx.code == LC_GO_U3)
                acc_cnt <= int'(acc_dly);
            else if (acc_cnt > 0)
                acc_cnt <= acc_cnt - 1;
            else if (acc_cnt == 0)
            begin
                // Acceptance is never withheld, only delayed
                lcmd_rx <= '{valid: 1'b1, code: LC_ACCEPT};
                acc_cnt <= -1;
            end
            if (wake_go)
                wake_pend <= 1'b1;
            else if (lfps_d && !lfps_tx)
                wake_pend <= 1'b0;
            lfps_rx_pin <= lfps_tx | wake_pend;
        end
    end
endmodule

// ==== testbench/lsw_port_test.sv ====
// Self-checking bench for the link suspend and wake sequencer
`timescale 1ns/1ns
module lsw_port_test
    import lsw_pkg::*;
();
    logic clk_sys, arst_n, link_u3_req, link_wake_req, func_wake_req, up_port_in_u3;
    logic up_lfps_rx_pin, link_chg_clr, erdy_in, xfer_busy, wake_go, lfps_rx_pin;
    logic tx_eidle, link_in_u3, lfps_tx, up_lfps_tx, link_chg, wake_notify, erdy_out, belt_upd;
    logic [7:0] acc_dly;
    logic [TOL_W-1:0] belt_val, prev_belt;
    lsw_belt_cfg_t belt_cfg;
    logic [NEP-1:0][TOL_W-1:0] ep_tol;
    logic [NEP-1:0] ep_cfg;
    lsw_lcmd_t lcmd_tx, lcmd_rx;
    int miscompares = 0;
    int check_count = 0;
    int n;
    // Host-side latency budget for a link with no hub above it, so t2 and t4 are zero
    localparam int HUBS = 0;
    localparam int EXIT_NS = 32;
    localparam int HOST_NS = 16;
    localparam int T2_NS = (HUBS == 0) ? 0 : ERDY_HOLD_NS + HUB_FWD_NS * (HUBS - 1);
    localparam int T4_NS = HUB_FWD_NS * HUBS;
    localparam logic [TOL_W-1:0] U1_SEL = TOL_W'(EXIT_NS + T2_NS + HOST_NS + T4_NS);

    lsw_port lsw_port_inst (.clk_sys, .arst_n, .link_u3_req, .link_wake_req, .func_wake_req,
        .up_port_in_u3, .lcmd_rx, .lfps_rx_pin, .up_lfps_rx_pin, .link_chg_clr, .erdy_in,
        .xfer_busy, .belt_cfg, .ep_tol, .ep_cfg, .lcmd_tx, .tx_eidle, .link_in_u3, .lfps_tx,
        .up_lfps_tx, .link_chg, .wake_notify, .erdy_out, .belt_val, .belt_upd);
    lsw_partner lsw_partner_inst (.clk_sys, .arst_n, .lcmd_tx, .lfps_tx, .acc_dly, .wake_go,
        .lcmd_rx, .lfps_rx_pin);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    function automatic logic probe(input int k);
        case (k)
            0: return link_in_u3;
            1: return lfps_tx;
            2: return up_lfps_tx;
            3: return erdy_out;
            default: return lcmd_tx.valid && lcmd_tx.code == LC_PM_ACK;
        endcase
    endfunction
    // Bounded wait; n holds the edges taken
    task automatic wait_on(input int k, input logic v, input int lim);
        n = 0;
        while (probe(k) !== v && n < lim)
        begin
            tick();
            n++;
        end
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        case (k)
            0: link_u3_req <= 1'b1;
            1: link_wake_req <= 1'b1;
            2: func_wake_req <= 1'b1;
            3: erdy_in <= 1'b1;
            4: link_chg_clr <= 1'b1;
            default: wake_go <= 1'b1;
        endcase
        @(posedge clk_sys);
        {link_u3_req, link_wake_req, func_wake_req, erdy_in, link_chg_clr, wake_go} <= '0;
        #1;
    endtask
    function automatic logic [TOL_W-1:0] exp_belt();
        logic [TOL_W:0] s;
        logic [TOL_W-1:0] m, sub;
        m = TOL_MAX;
        for (int i = 0; i < NEP; i++)
            if (ep_cfg[i] && ep_tol[i] < m)
                m = ep_tol[i];
        s = {1'b0, m} + {1'b0, belt_cfg.idle_bonus};
        if (s[TOL_W])
            s = {1'b0, TOL_MAX};
        sub = belt_cfg.u2_en ? belt_cfg.u2_sel : (belt_cfg.u1_en ? belt_cfg.u1_sel : TOL_ZERO);
        return (s[TOL_W-1:0] > sub) ? s[TOL_W-1:0] - sub : TOL_ZERO;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic belt_case(input logic [3:0] mask, input logic [1:0] en, input logic [15:0] b);
        @(posedge clk_sys);
        ep_cfg <= mask;
        {belt_cfg.u2_en, belt_cfg.u1_en} <= en;
        belt_cfg.idle_bonus <= b;
        tick();
        check(belt_val, exp_belt());
        check(belt_upd, exp_belt() != prev_belt);
        prev_belt = exp_belt();
        tick();
    endtask
    task automatic suspend(input logic [7:0] dly);
        @(posedge clk_sys);
        acc_dly <= dly;
        pulse(0);
        check(lcmd_tx, {1'b1, LC_GO_U3});
        wait_on(4, 1'b1, 300);
        check({probe(4), tx_eidle, 30'(n)}, {2'b10, 30'(dly + 3)});
        tick();
        check({tx_eidle, link_in_u3}, 2'b11);
    endtask
    task automatic test_host_wake();
        suspend(8'h05);
        pulse(0);
        check(lcmd_tx.valid, 1'b0);
        pulse(1);
        check(lfps_tx, 1'b1);
        wait_on(0, 1'b0, 80);
        check({link_in_u3, tx_eidle, lfps_tx, link_chg, wake_notify}, 5'b00010);
        check(n >= LFPS_HS_CYC, 1'b1);
        pulse(4);
        check(link_chg, 1'b0);
        pulse(1);
        check(lfps_tx, 1'b0);
    endtask
    task automatic test_remote(input logic up);
        suspend(8'h00);
        @(posedge clk_sys);
        up_port_in_u3 <= up;
        pulse(5);
        if (up)
        begin
            wait_on(2, 1'b1, 10);
            check({up_lfps_tx, lfps_tx}, 2'b10);
            repeat (4) tick();
            @(posedge clk_sys);
            up_lfps_rx_pin <= 1'b1;
        end
        wait_on(1, 1'b1, 10);
        check({up_lfps_tx, lfps_tx}, 2'b01);
        wait_on(0, 1'b0, 80);
        check({link_in_u3, link_chg, wake_notify}, 3'b000);
        @(posedge clk_sys);
        up_lfps_rx_pin <= 1'b0;
        up_port_in_u3 <= 1'b0;
        repeat (4) tick();
    endtask
    task automatic test_local_wake();
        suspend(8'h02);
        pulse(2);
        check(lfps_tx, 1'b1);
        wait_on(0, 1'b0, 80);
        check({link_chg, wake_notify}, 2'b01);
        tick();
        check(wake_notify, 1'b0);
    endtask
    task automatic test_erdy(input logic busy);
        @(posedge clk_sys);
        xfer_busy <= busy;
        pulse(3);
        wait_on(3, 1'b1, 80);
        check(probe(3), 1'b1);
        if (busy)
            check(n, ERDY_HOLD_CYC);
        else
            check(n, HUB_FWD_CYC);
        @(posedge clk_sys);
        xfer_busy <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        #(CLK_PERIOD_NS * 4000);
        miscompares++;
        give_verdict();
    end
    initial
    begin
        arst_n = 1'b0;
        {link_u3_req, link_wake_req, func_wake_req, up_port_in_u3, up_lfps_rx_pin} = '0;
        {link_chg_clr, erdy_in, xfer_busy, wake_go} = '0;
        acc_dly = 8'h00;
        ep_tol = {16'h0050, 16'h0900, 16'h0100, 16'h0400};
        ep_cfg = 4'hF;
        belt_cfg = '{u1_en: 1'b1, u2_en: 1'b0, u1_sel: U1_SEL, u2_sel: 16'h00C0,
            idle_bonus: 16'h0000};
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        tick();
        check({link_in_u3, tx_eidle, lfps_tx, up_lfps_tx, link_chg, lcmd_tx}, 8'h00);
        check(belt_val, exp_belt());
        prev_belt = exp_belt();
        belt_case(4'h7, 2'b11, 16'h0000);
        belt_case(4'hF, 2'b01, 16'h0000);
        belt_case(4'hF, 2'b11, 16'h0000);
        belt_case(4'h0, 2'b00, 16'h0000);
        belt_case(4'h1, 2'b10, 16'hFF00);
        $display("test belt done");
        test_erdy(1'b0);
        test_erdy(1'b1);
        $display("test erdy done");
        test_host_wake();
        $display("test host wake done");
        test_remote(1'b0);
        test_remote(1'b1);
        $display("test remote wake done");
        test_local_wake();
        $display("test local wake done");
        give_verdict();
    end
endmodule
